// ### design/nqrb_reply_builder.v
`timescale 1ns/1ps
`include "nqrb_map.vh"

module nqrb_reply_builder (
   input wire mclk,
   input wire arst_n,
   input wire q_valid,
   output reg q_ready_reg,
   input wire [7:0] q_port,
   input wire [15:0] q_tag,
   input wire [7:0] q_version,
   input wire [31:0] q_return_path,
   input wire [63:0] q_sender_id,
   input wire q_skip_registration_flag,
   input wire [2:0] q_master_prio,
   input wire [63:0] node_identifier,
   input wire [7:0] ulp_code,
   input wire master_capable,
   input wire prio_override_en,
   input wire [2:0] prio_override,
   input wire [7:0] other_ports,
   input wire port1_up,
   input wire port2_up,
   input wire long_reach_fitted,
   input wire node_is_master,
   input wire tbl_clear,
   output reg tx_valid_reg,
   input wire tx_ready,
   output reg [7:0] tx_data_reg,
   output reg tx_first_reg,
   output reg tx_last_reg,
   output reg [7:0] tx_port_reg,
   output reg [31:0] tx_path_reg,
   output reg master_resign_reg,
   output reg busy_reg
);

   // ****************************************
   // States
   // ****************************************
   localparam ST_IDLE = 2'b00;
   localparam ST_REG = 2'b01;
   localparam ST_LOAD = 2'b10;
   localparam ST_SEND = 2'b11;

   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [4:0] idx_reg;
   reg [4:0] sel_idx;
   reg [7:0] sel_byte;
   reg [15:0] tag_reg;
   reg [7:0] ver_reg;
   reg [7:0] ulp_reg;
   reg [2:0] prio_reg;
   reg [7:0] other_reg;
   reg [63:0] id_reg;
   reg [31:0] token_reg;
   reg full_reg;
   reg p1_reg;
   reg p2_reg;
   reg long_reg;
   reg cm_reg;
   reg resign_pend_reg;
   reg tbl_req_reg;
   reg [2:0] own_prio;
   wire accept;
   wire tbl_done;
   wire tbl_full;
   wire [31:0] tbl_token;
   wire is_switch;

   // ****************************************
   // Helper functions
   // ****************************************
   function [7:0] nqrb_pick_version;
      input [7:0] asked;
      begin
         if (asked >= `NQRB_VER_THIS) begin
            nqrb_pick_version = `NQRB_VER_THIS;
         end else if (asked >= `NQRB_VER_OLD_STD) begin
            nqrb_pick_version = `NQRB_VER_OLD_STD;
         end else begin
            nqrb_pick_version = `NQRB_VER_PRE_STD;
         end
      end
   endfunction

   function [7:0] nqrb_legal_ulp;
      input [7:0] code;
      begin
         case (code)
            `NQRB_ULP_LIST,
            `NQRB_ULP_NONE,
            `NQRB_ULP_VENDOR,
            `NQRB_ULP_PROTO_A,
            `NQRB_ULP_PROTO_B,
            `NQRB_ULP_PROTO_C: begin
               nqrb_legal_ulp = code;
            end
            default: begin
               nqrb_legal_ulp = `NQRB_ULP_NONE;
            end
         endcase
      end
   endfunction

   // ****************************************
   // Configuring-node table
   // ****************************************
   nqrb_config_table u_table (
      .mclk(mclk),
      .arst_n(arst_n),
      .tbl_clear(tbl_clear),
      .reg_req(tbl_req_reg),
      .reg_skip(q_skip_registration_flag),
      .sender_id(q_sender_id),
      .sender_path(q_return_path),
      .done_reg(tbl_done),
      .full_reg(tbl_full),
      .token_reg(tbl_token)
   );

   assign accept = q_valid && q_ready_reg;
   assign is_switch = (other_ports > 8'h01);

   // Own priority: override, default 4, or responder
   always @* begin
      if (!master_capable) begin
         own_prio = `NQRB_PRIO_RESPONDER;
      end else if (prio_override_en && prio_override != `NQRB_PRIO_RESPONDER) begin
         own_prio = prio_override;
      end else begin
         own_prio = `NQRB_PRIO_DEFAULT;
      end
   end

   // ****************************************
   // Sequencer
   // ****************************************
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (accept) begin
               state_next = ST_REG;
            end
         end
         ST_REG: begin
            if (tbl_done) begin
               state_next = ST_LOAD;
            end
         end
         ST_LOAD: begin
            state_next = ST_SEND;
         end
         ST_SEND: begin
            if (tx_ready && idx_reg == `NQRB_LAST_IDX) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // ****************************************
   // Reply byte selection
   // ****************************************
   always @* begin
      if (state_reg == ST_LOAD) begin
         sel_idx = `NQRB_IDX_CODE;
      end else begin
         sel_idx = idx_reg + 5'd1;
      end
      case (sel_idx)
         `NQRB_IDX_CODE: sel_byte = `NQRB_ANSWER_CODE;
         `NQRB_IDX_PORT: sel_byte = tx_port_reg;
         `NQRB_IDX_TAG_HI: sel_byte = tag_reg[15:8];
         `NQRB_IDX_TAG_LO: sel_byte = tag_reg[7:0];
         `NQRB_IDX_ULP: sel_byte = ulp_reg;
         `NQRB_IDX_PRIO: sel_byte = {full_reg, prio_reg, 4'h0};
         `NQRB_IDX_OTHER: sel_byte = other_reg;
         `NQRB_IDX_VER: sel_byte = ver_reg;
         5'd8: sel_byte = id_reg[63:56];
         5'd9: sel_byte = id_reg[55:48];
         5'd10: sel_byte = id_reg[47:40];
         5'd11: sel_byte = id_reg[39:32];
         5'd12: sel_byte = id_reg[31:24];
         5'd13: sel_byte = id_reg[23:16];
         5'd14: sel_byte = id_reg[15:8];
         `NQRB_IDX_ID_LAST: sel_byte = id_reg[7:0];
         `NQRB_IDX_TOKEN_FIRST: sel_byte = token_reg[31:24];
         5'd17: sel_byte = token_reg[23:16];
         5'd18: sel_byte = token_reg[15:8];
         `NQRB_IDX_TOKEN_LAST: sel_byte = token_reg[7:0];
         `NQRB_IDX_FLAGS: sel_byte = {p1_reg, p2_reg, long_reg, cm_reg, 4'h0};
         default: sel_byte = 8'h00;
      endcase
   end

   // ****************************************
   // Inquiry capture
   // ****************************************
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         tag_reg <= 16'h0000;
         ver_reg <= 8'h00;
         ulp_reg <= 8'h00;
         prio_reg <= 3'b000;
         other_reg <= 8'h00;
         id_reg <= 64'h0000_0000_0000_0000;
         p1_reg <= 1'b0;
         p2_reg <= 1'b0;
         long_reg <= 1'b0;
         cm_reg <= 1'b0;
      end else begin
         if (accept) begin
            tag_reg <= q_tag;
            ver_reg <= nqrb_pick_version(q_version);
            ulp_reg <= nqrb_legal_ulp(ulp_code);
            prio_reg <= own_prio;
            other_reg <= other_ports;
            id_reg <= node_identifier;
            p1_reg <= port1_up && !is_switch;
            p2_reg <= port2_up && !is_switch;
            long_reg <= long_reach_fitted;
            cm_reg <= node_is_master;
         end
      end
   end

   // ****************************************
   // Return route capture
   // ****************************************
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         tx_port_reg <= 8'h00;
         tx_path_reg <= 32'h0000_0000;
         resign_pend_reg <= 1'b0;
      end else if (accept) begin
         tx_port_reg <= q_port;
         tx_path_reg <= q_return_path;
         resign_pend_reg <= node_is_master && (q_master_prio > own_prio);
      end
   end

   // ****************************************
   // Table request strobe
   // ****************************************
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         tbl_req_reg <= 1'b0;
      end else begin
         tbl_req_reg <= accept;
      end
   end

   // ****************************************
   // State register and byte output
   // ****************************************
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= ST_IDLE;
         idx_reg <= 5'd0;
         tx_valid_reg <= 1'b0;
         tx_data_reg <= 8'h00;
         tx_first_reg <= 1'b0;
         tx_last_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (state_reg == ST_LOAD) begin
            idx_reg <= `NQRB_IDX_CODE;
            tx_valid_reg <= 1'b1;
            tx_data_reg <= sel_byte;
            tx_first_reg <= 1'b1;
            tx_last_reg <= 1'b0;
         end else if (state_reg == ST_SEND && tx_ready) begin
            tx_first_reg <= 1'b0;
            if (idx_reg == `NQRB_LAST_IDX) begin
               // Frame ends at byte 20; no padding is emitted
               tx_valid_reg <= 1'b0;
               tx_last_reg <= 1'b0;
               tx_data_reg <= 8'h00;
            end else begin
               idx_reg <= sel_idx;
               tx_data_reg <= sel_byte;
               tx_last_reg <= (sel_idx == `NQRB_LAST_IDX);
            end
         end
      end
   end

   // ****************************************
   // Inquiry handshake and status
   // ****************************************
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         q_ready_reg <= 1'b0;
         busy_reg <= 1'b0;
         master_resign_reg <= 1'b0;
      end else begin
         q_ready_reg <= (state_next == ST_IDLE);
         busy_reg <= (state_next != ST_IDLE);
         master_resign_reg <= resign_pend_reg && state_reg == ST_SEND && tx_ready
            && idx_reg == `NQRB_LAST_IDX;
      end
   end

   // ****************************************
   // Table result capture
   // ****************************************
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         full_reg <= 1'b0;
         token_reg <= 32'h0000_0000;
      end else if (state_reg == ST_REG && tbl_done) begin
         full_reg <= tbl_full;
         token_reg <= tbl_token;
      end
   end

endmodule

// ### design/nqrb_map.vh
`ifndef NQRB_MAP_VH
`define NQRB_MAP_VH

// ****************************************
// Reply message layout
// ****************************************
`define NQRB_ANSWER_CODE 8'h01
`define NQRB_REPLY_LEN 5'd21
`define NQRB_LAST_IDX 5'd20
`define NQRB_IDX_CODE 5'd0
`define NQRB_IDX_PORT 5'd1
`define NQRB_IDX_TAG_HI 5'd2
`define NQRB_IDX_TAG_LO 5'd3
`define NQRB_IDX_ULP 5'd4
`define NQRB_IDX_PRIO 5'd5
`define NQRB_IDX_OTHER 5'd6
`define NQRB_IDX_VER 5'd7
`define NQRB_IDX_ID_FIRST 5'd8
`define NQRB_IDX_ID_LAST 5'd15
`define NQRB_IDX_TOKEN_FIRST 5'd16
`define NQRB_IDX_TOKEN_LAST 5'd19
`define NQRB_IDX_FLAGS 5'd20

// ****************************************
// Transport versions
// ****************************************
`define NQRB_VER_THIS 8'h10
`define NQRB_VER_OLD_STD 8'h02
`define NQRB_VER_PRE_STD 8'h00

// ****************************************
// Upper-level protocol codes
// ****************************************
`define NQRB_ULP_LIST 8'h00
`define NQRB_ULP_NONE 8'h01
`define NQRB_ULP_VENDOR 8'h02
`define NQRB_ULP_PROTO_A 8'h80
`define NQRB_ULP_PROTO_B 8'h82
`define NQRB_ULP_PROTO_C 8'h83

// ****************************************
// Master priority
// ****************************************
`define NQRB_PRIO_RESPONDER 3'b000
`define NQRB_PRIO_DEFAULT 3'b100

// ****************************************
// Configuring-node table
// ****************************************
`define NQRB_TBL_DEPTH 4
`define NQRB_TBL_IDX_W 2
`define NQRB_TOKEN_NOSLOT 8'hFF

`endif

// ### design/nqrb_config_table.v
`timescale 1ns/1ps
`include "nqrb_map.vh"

module nqrb_config_table (
   input wire mclk,
   input wire arst_n,
   input wire tbl_clear,
   input wire reg_req,
   input wire reg_skip,
   input wire [63:0] sender_id,
   input wire [31:0] sender_path,
   output reg done_reg,
   output reg full_reg,
   output reg [31:0] token_reg
);

   reg ent_valid_reg [0:`NQRB_TBL_DEPTH-1];
   reg [63:0] ent_id_reg [0:`NQRB_TBL_DEPTH-1];
   reg [31:0] ent_path_reg [0:`NQRB_TBL_DEPTH-1];
   reg [31:0] ent_token_reg [0:`NQRB_TBL_DEPTH-1];
   reg [23:0] gen_reg;
   reg hit;
   reg free_found;
   reg [`NQRB_TBL_IDX_W-1:0] hit_idx;
   reg [`NQRB_TBL_IDX_W-1:0] free_idx;
   integer i;
   integer j;

   // ****************************************
   // Lookup of matching and free slots
   // ****************************************
   always @* begin
      hit = 1'b0;
      free_found = 1'b0;
      hit_idx = {`NQRB_TBL_IDX_W{1'b0}};
      free_idx = {`NQRB_TBL_IDX_W{1'b0}};
      for (i = `NQRB_TBL_DEPTH - 1; i >= 0; i = i - 1) begin
         if (ent_valid_reg[i] && ent_id_reg[i] == sender_id
             && ent_path_reg[i] == sender_path) begin
            hit = 1'b1;
            hit_idx = i[`NQRB_TBL_IDX_W-1:0];
         end
         if (!ent_valid_reg[i]) begin
            free_found = 1'b1;
            free_idx = i[`NQRB_TBL_IDX_W-1:0];
         end
      end
   end

   // ****************************************
   // Registration and token hand-out
   // ****************************************
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         done_reg <= 1'b0;
         full_reg <= 1'b0;
         token_reg <= 32'h0000_0000;
         gen_reg <= 24'h00_0000;
         for (j = 0; j < `NQRB_TBL_DEPTH; j = j + 1) begin
            ent_valid_reg[j] <= 1'b0;
            ent_id_reg[j] <= 64'h0000_0000_0000_0000;
            ent_path_reg[j] <= 32'h0000_0000;
            ent_token_reg[j] <= 32'h0000_0000;
         end
      end else begin
         done_reg <= reg_req;
         if (tbl_clear) begin
            for (j = 0; j < `NQRB_TBL_DEPTH; j = j + 1) begin
               ent_valid_reg[j] <= 1'b0;
            end
         end
         if (reg_req) begin
            gen_reg <= gen_reg + 24'h00_0001;
            full_reg <= !hit && !free_found;
            if (hit) begin
               token_reg <= ent_token_reg[hit_idx];
            end else if (!reg_skip && free_found) begin
               // New entry only when registration is allowed
               ent_valid_reg[free_idx] <= 1'b1;
               ent_id_reg[free_idx] <= sender_id;
               ent_path_reg[free_idx] <= sender_path;
               ent_token_reg[free_idx] <= {gen_reg, 6'b00_0000, free_idx};
               token_reg <= {gen_reg, 6'b00_0000, free_idx};
            end else begin
               token_reg <= {gen_reg, `NQRB_TOKEN_NOSLOT};
            end
         end
      end
   end

endmodule

// ### testbench/nqrb_sink.sv
`timescale 1ns/1ps
module nqrb_sink (
   input wire mclk,
   input wire arst_n,
   input wire slow,
   input wire tx_valid,
   input wire [7:0] tx_data,
   input wire tx_first,
   input wire tx_last,
   output reg tx_ready
);
   reg [7:0] got [0:20];
   reg [4:0] cnt_reg;
   integer frames;
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         tx_ready <= 1'b0;
         cnt_reg <= 5'd0;
         frames <= 0;
      end else begin
         // Slow mode stalls every other cycle
         tx_ready <= slow ? !tx_ready : 1'b1;
         if (tx_valid && tx_ready && (tx_first || cnt_reg <= 5'd20)) begin
            got[tx_first ? 5'd0 : cnt_reg] <= tx_data;
            cnt_reg <= tx_first ? 5'd1 : cnt_reg + 5'd1;
            if (tx_last) begin
               frames <= frames + 1;
            end
         end
      end
   end
endmodule

// ### testbench/nqrb_reply_builder_checker.sv
`timescale 1ns/1ps
module nqrb_reply_builder_checker (
   input wire mclk,
   input wire arst_n,
   input wire q_valid,
   input wire q_ready_reg,
   input wire [7:0] q_port,
   input wire [31:0] q_return_path,
   input wire master_capable,
   input wire [7:0] other_ports,
   input wire long_reach_fitted,
   input wire node_is_master,
   input wire tx_valid_reg,
   input wire tx_ready,
   input wire [7:0] tx_data_reg,
   input wire tx_first_reg,
   input wire tx_last_reg,
   input wire [7:0] tx_port_reg,
   input wire [31:0] tx_path_reg,
   input wire master_resign_reg
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   reg [4:0] idx_reg;
   wire take = q_valid && q_ready_reg;
   wire hs = tx_valid_reg && tx_ready;
   wire hs_last = hs && tx_last_reg;
   wire [7:0] d = tx_data_reg;
   // ****************************************
   // Byte position tracker
   // ****************************************
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         idx_reg <= 5'd0;
      end else if (hs) begin
         idx_reg <= tx_last_reg ? 5'd0 : idx_reg + 5'd1;
      end
   end
   wire at1 = tx_valid_reg && idx_reg == 5'd1;
   wire at4 = tx_valid_reg && idx_reg == 5'd4;
   wire at5 = tx_valid_reg && idx_reg == 5'd5;
   wire at7 = tx_valid_reg && idx_reg == 5'd7;
   wire at20 = tx_valid_reg && idx_reg == 5'd20;
   property p_accept;
      take |-> ##4 (tx_valid_reg && tx_first_reg && d == 8'h01);
   endproperty
   a_accept: assert property (p_accept) else $error("reply start wrong");
   property p_route;
      take |=> tx_port_reg == $past(q_port) && tx_path_reg == $past(q_return_path);
   endproperty
   a_route: assert property (p_route) else $error("route wrong");
   property p_port;
      at1 |-> d == tx_port_reg;
   endproperty
   a_port: assert property (p_port) else $error("port byte wrong");
   property p_ulp;
      at4 |-> d inside {8'h00, 8'h01, 8'h02, 8'h80, 8'h82, 8'h83};
   endproperty
   a_ulp: assert property (p_ulp) else $error("protocol code illegal");
   property p_prio;
      at5 |-> d[3:0] == 4'h0 && (master_capable || d[6:4] == 3'b000);
   endproperty
   a_prio: assert property (p_prio) else $error("priority byte wrong");
   property p_ver;
      at7 |-> d inside {8'h10, 8'h02, 8'h00};
   endproperty
   a_ver: assert property (p_ver) else $error("version wrong");
   property p_flags;
      at20 |-> tx_last_reg && d[3:0] == 4'h0 && d[5:4] == {long_reach_fitted, node_is_master};
   endproperty
   a_flags: assert property (p_flags) else $error("flags wrong");
   property p_switch;
      at20 && other_ports > 8'h01 |-> d[7:6] == 2'b00;
   endproperty
   a_switch: assert property (p_switch) else $error("switch port flags set");
   property p_hold;
      tx_valid_reg && !tx_ready |=> tx_valid_reg && $stable(tx_data_reg) && !q_ready_reg;
   endproperty
   a_hold: assert property (p_hold) else $error("byte lost in stall");
   property p_resign;
      master_resign_reg |-> $past(hs_last) || $past(hs_last, 2);
   endproperty
   a_resign: assert property (p_resign) else $error("resign not after reply");
   c_full: cover property (at5 && d[7]);
   c_resign: cover property (master_resign_reg);
   c_stall: cover property (tx_valid_reg && !tx_ready);
endmodule
bind nqrb_reply_builder nqrb_reply_builder_checker u_chk (.mclk(mclk), .arst_n(arst_n),
   .q_valid(q_valid), .q_ready_reg(q_ready_reg), .q_port(q_port),
   .q_return_path(q_return_path), .master_capable(master_capable), .other_ports(other_ports),
   .long_reach_fitted(long_reach_fitted), .node_is_master(node_is_master),
   .tx_valid_reg(tx_valid_reg), .tx_ready(tx_ready), .tx_data_reg(tx_data_reg),
   .tx_first_reg(tx_first_reg), .tx_last_reg(tx_last_reg), .tx_port_reg(tx_port_reg),
   .tx_path_reg(tx_path_reg), .master_resign_reg(master_resign_reg));

// ### testbench/nqrb_reply_builder_test.sv
`timescale 1ns/1ps
module nqrb_reply_builder_test;
   reg mclk, arst_n, q_valid, q_skip_registration_flag, master_capable, prio_override_en;
   reg port1_up, port2_up, long_reach_fitted, node_is_master, tbl_clear, slow, resign_seen;
   reg [7:0] q_port, q_version, ulp_code, other_ports;
   reg [15:0] q_tag;
   reg [31:0] q_return_path, tok, tok0;
   reg [63:0] q_sender_id, node_identifier;
   reg [2:0] q_master_prio, prio_override;
   wire q_ready_reg, tx_valid_reg, tx_ready, tx_first_reg, tx_last_reg, master_resign_reg;
   wire busy_reg;
   wire [7:0] tx_data_reg, tx_port_reg;
   wire [31:0] tx_path_reg;
   integer bad_count = 0, checks_done = 0;
   reg [7:0] ulps [0:6] = '{8'h00, 8'h01, 8'h02, 8'h80, 8'h82, 8'h83, 8'h03};
   reg [7:0] vers [0:6] = '{8'h10, 8'h11, 8'h02, 8'h05, 8'h00, 8'h01, 8'hff};
   reg [7:0] oths [0:6] = '{8'h00, 8'h01, 8'h03, 8'h00, 8'h01, 8'h05, 8'h00};
   nqrb_reply_builder u_dut (.mclk(mclk), .arst_n(arst_n), .q_valid(q_valid),
      .q_ready_reg(q_ready_reg), .q_port(q_port), .q_tag(q_tag), .q_version(q_version),
      .q_return_path(q_return_path), .q_sender_id(q_sender_id),
      .q_skip_registration_flag(q_skip_registration_flag), .q_master_prio(q_master_prio),
      .node_identifier(node_identifier), .ulp_code(ulp_code), .master_capable(master_capable),
      .prio_override_en(prio_override_en), .prio_override(prio_override),
      .other_ports(other_ports), .port1_up(port1_up), .port2_up(port2_up),
      .long_reach_fitted(long_reach_fitted), .node_is_master(node_is_master),
      .tbl_clear(tbl_clear), .tx_valid_reg(tx_valid_reg), .tx_ready(tx_ready),
      .tx_data_reg(tx_data_reg), .tx_first_reg(tx_first_reg), .tx_last_reg(tx_last_reg),
      .tx_port_reg(tx_port_reg), .tx_path_reg(tx_path_reg),
      .master_resign_reg(master_resign_reg), .busy_reg(busy_reg));
   nqrb_sink u_sink (.mclk(mclk), .arst_n(arst_n), .slow(slow), .tx_valid(tx_valid_reg),
      .tx_data(tx_data_reg), .tx_first(tx_first_reg), .tx_last(tx_last_reg),
      .tx_ready(tx_ready));
   initial begin
      mclk = 0;
      forever #12.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      if (master_resign_reg === 1'b1) resign_seen <= 1'b1;
      else if (q_valid) resign_seen <= 1'b0;
   end
   task automatic chk(input [63:0] seen, input [63:0] want);
      checks_done++;
      if (seen !== want) begin
         bad_count++;
         $display("[ERR] %0t got %h want %h", $time, seen, want);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // ****************************************
   // One inquiry, reply compared except token bytes 16-19
   // ****************************************
   task automatic query(input [63:0] sid, input [31:0] path, input skip, input [2:0] mp,
         input full);
      integer i, f0;
      reg [2:0] pr;
      reg [7:0] ul, vx;
      reg sw;
      @(posedge mclk);
      #1;
      q_sender_id = sid;
      q_return_path = path;
      q_skip_registration_flag = skip;
      q_master_prio = mp;
      q_tag = q_tag + 16'h10f1;
      q_port = q_port + 8'h01;
      q_valid = 1'b1;
      i = 0;
      while (q_ready_reg !== 1'b1 && i < 100) begin
         @(posedge mclk);
         #1;
         i++;
      end
      f0 = u_sink.frames;
      @(posedge mclk);
      #1;
      q_valid = 1'b0;
      @(posedge mclk);
      #1;
      chk(tx_port_reg, q_port);
      chk(tx_path_reg, path);
      chk(busy_reg, 1'b1);
      i = 0;
      while (u_sink.frames == f0 && i < 200) begin
         @(posedge mclk);
         #1;
         i++;
      end
      repeat (3) @(posedge mclk);
      #1;
      chk(u_sink.frames, f0 + 1);
      chk(busy_reg, 1'b0);
      pr = !master_capable ? 3'b000 :
         (prio_override_en && prio_override != 3'b000) ? prio_override : 3'b100;
      ul = (ulp_code inside {8'h00, 8'h01, 8'h02, 8'h80, 8'h82, 8'h83}) ? ulp_code : 8'h01;
      vx = q_version >= 8'h10 ? 8'h10 : q_version >= 8'h02 ? 8'h02 : 8'h00;
      sw = other_ports > 8'h01;
      chk(u_sink.got[0], 8'h01);
      chk(u_sink.got[1], q_port);
      chk(u_sink.got[2], q_tag[15:8]);
      chk(u_sink.got[3], q_tag[7:0]);
      chk(u_sink.got[4], ul);
      chk(u_sink.got[5], {full, pr, 4'h0});
      chk(u_sink.got[6], other_ports);
      chk(u_sink.got[7], vx);
      for (i = 8; i < 16; i++) begin
         chk(u_sink.got[i], node_identifier[127 - 8 * i -: 8]);
      end
      chk(u_sink.got[20], {!sw && port1_up, !sw && port2_up, long_reach_fitted,
         node_is_master, 4'h0});
      tok = {u_sink.got[16], u_sink.got[17], u_sink.got[18], u_sink.got[19]};
      chk(resign_seen, node_is_master && master_capable && mp > pr);
   endtask
   task automatic clear_table;
      @(posedge mclk);
      #1;
      tbl_clear = 1'b1;
      @(posedge mclk);
      #1;
      tbl_clear = 1'b0;
   endtask
   task automatic t_fields;
      integer k;
      clear_table();
      for (k = 0; k < 7; k++) begin
         ulp_code = ulps[k];
         q_version = vers[k];
         other_ports = oths[k];
         port1_up = k[0];
         port2_up = k[1];
         long_reach_fitted = k[2];
         master_capable = (k != 3);
         prio_override_en = k[1];
         prio_override = (k == 2) ? 3'b111 : 3'b000;
         query(64'h0a0b_0c0d_0e0f_1011 + k, 32'h2000_0000 + k, 1'b1, 3'b001, 1'b0);
      end
   endtask
   task automatic t_table;
      integer j;
      clear_table();
      query(64'h7777_0000_0000_0001, 32'h3000_0000, 1'b1, 3'b000, 1'b0);
      for (j = 0; j < 4; j++) begin
         query(64'h5555_0000_0000_0000 + j, 32'h1000_0000 + j, 1'b0, 3'b000, 1'b0);
         if (j == 0) tok0 = tok;
      end
      query(64'h5555_0000_0000_0009, 32'h1000_0009, 1'b0, 3'b000, 1'b1);
      query(64'h5555_0000_0000_0000, 32'h1000_0000, 1'b0, 3'b000, 1'b0);
      chk(tok, tok0);
   endtask
   task automatic t_resign;
      clear_table();
      slow = 1'b1;
      master_capable = 1'b1;
      prio_override_en = 1'b0;
      node_is_master = 1'b1;
      query(64'h6666_0000_0000_0001, 32'h4000_0001, 1'b1, 3'b101, 1'b0);
      query(64'h6666_0000_0000_0002, 32'h4000_0002, 1'b1, 3'b100, 1'b0);
      node_is_master = 1'b0;
      query(64'h6666_0000_0000_0003, 32'h4000_0003, 1'b1, 3'b111, 1'b0);
      slow = 1'b0;
   endtask
   initial begin
      #(25 * 8000);
      bad_count++;
      tally_and_finish();
   end
   initial begin
      arst_n = 0; q_valid = 0; q_skip_registration_flag = 0; master_capable = 1;
      prio_override_en = 0; prio_override = 3'b000; port1_up = 0; port2_up = 0;
      long_reach_fitted = 0; node_is_master = 0; tbl_clear = 0; slow = 0;
      q_port = 8'h00; q_version = 8'h10; ulp_code = 8'h01; other_ports = 8'h01;
      q_tag = 16'h0000; q_return_path = 32'h0000_0000; q_sender_id = 64'h0000_0000_0000_0000;
      node_identifier = 64'h0123_4567_89ab_cdef;
      q_master_prio = 3'b000;
      repeat (8) @(posedge mclk);
      #1;
      arst_n = 1;
      t_fields();
      t_table();
      t_resign();
      tally_and_finish();
   end
endmodule
